/* logic/fds_pkg.sv */
// Package: register map, field positions and reset values for fault/select
package fds_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_SELECT = 8'h08;

  // ==========================================================
  // Fields
  localparam int BIT_ERASE = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_DEV0 = 0;
  localparam int BIT_DEV1 = 1;
  localparam int BIT_DEV2 = 2;
  localparam int FAULT_W = 2;
  localparam int SEL_W = 3;

  localparam logic [FAULT_W-1:0] FAULT_RST = 2'h0;
  localparam logic [FAULT_W-1:0] MASK_RST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_FIRST = 3'h1;
  localparam logic [SEL_W-1:0] SEL_SECOND = 3'h2;
  localparam logic [SEL_W-1:0] SEL_THIRD = 3'h4;
  localparam logic [SEL_W-1:0] SEL_RAW_RST = 3'h0;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;

endpackage : fds_pkg

/* logic/fds_decode.sv */
// Decoder from the raw select register to a one-hot device select
`timescale 1ns/1ns
module fds_decode
(
  input wire logic [fds_pkg::SEL_W-1:0] raw,
  output logic [fds_pkg::SEL_W-1:0] onehot
);

  always_comb
  begin
    // Anything not exactly one of the upper bits falls back to device one
    if (raw[fds_pkg::BIT_DEV2] && !raw[fds_pkg::BIT_DEV1] &&
        !raw[fds_pkg::BIT_DEV0])
      onehot = fds_pkg::SEL_THIRD;
    else if (raw[fds_pkg::BIT_DEV1] && !raw[fds_pkg::BIT_DEV2] &&
             !raw[fds_pkg::BIT_DEV0])
      onehot = fds_pkg::SEL_SECOND;
    else
      onehot = fds_pkg::SEL_FIRST;
  end

endmodule : fds_decode

/* logic/fds_regs.sv */
// Fault status, interrupt enable and target device select over AHB-Lite
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ns
module fds_regs
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic illegal_write_evt,
  input wire logic illegal_erase_evt,
  output logic write_cancel,
  output logic erase_cancel,
  output logic [fds_pkg::SEL_W-1:0] device_select,
  output logic irq
);

  // ==========================================================
  // Bus address phase capture
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  logic hreadyout_nxt;
  logic hresp_r;
  logic hresp_nxt;
  logic access;

  // ==========================================================
  // Register state
  logic [fds_pkg::FAULT_W-1:0] status_r;
  logic [fds_pkg::FAULT_W-1:0] status_nxt;
  logic [fds_pkg::FAULT_W-1:0] mask_r;
  logic [fds_pkg::FAULT_W-1:0] mask_nxt;
  logic [fds_pkg::SEL_W-1:0] sel_raw_r;
  logic [fds_pkg::SEL_W-1:0] sel_raw_nxt;
  logic [fds_pkg::SEL_W-1:0] sel_r;
  logic [fds_pkg::SEL_W-1:0] sel_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wcan_r;
  logic wcan_nxt;
  logic ecan_r;
  logic ecan_nxt;
  logic [fds_pkg::FAULT_W-1:0] wr_status;
  logic [fds_pkg::FAULT_W-1:0] set_vec;

  function automatic logic is_word_access(input logic [1:0] tr,
                                          input logic [2:0] sz,
                                          input logic [1:0] lsb);
    is_word_access = (tr == fds_pkg::HTRANS_NONSEQ ||
                      tr == fds_pkg::HTRANS_SEQ) &&
                     sz == fds_pkg::HSIZE_WORD &&
                     lsb == fds_pkg::ADDR_LSB_ZERO;
  endfunction : is_word_access

  function automatic logic write_to(input logic pend,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    write_to = pend && addr == target;
  endfunction : write_to

  assign access = hsel && hready && is_word_access(htrans, hsize, haddr[1:0]);

  // ==========================================================
  // Select decode
  // Decoding the incoming value lets the output move with the register
  fds_decode u_decode
  (
    .raw(sel_raw_nxt),
    .onehot(sel_nxt)
  );

  // ==========================================================
  // Bus next state
  // Zero wait states; a read returns what the register holds in its
  // data phase, so a read right after a write sees the new value
  always_comb
  begin
    wr_pend_nxt = access && hwrite;
    wr_addr_nxt = access ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = '0;
    if (access && !hwrite)
    begin
      case (haddr[7:0])
        fds_pkg::ADDR_STATUS: hrdata_nxt[fds_pkg::FAULT_W-1:0] = status_nxt;
        fds_pkg::ADDR_MASK: hrdata_nxt[fds_pkg::FAULT_W-1:0] = mask_nxt;
        // Select register is write-only; it reads as zero
        default: hrdata_nxt = '0;
      endcase
    end
    hreadyout_nxt = 1'b1;
    hresp_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= hreadyout_nxt;
      hresp_r <= hresp_nxt;
    end
  end

  // ==========================================================
  // Fault status flags and cancel pulses
  always_comb
  begin
    set_vec = '0;
    set_vec[fds_pkg::BIT_WRITE] = illegal_write_evt;
    set_vec[fds_pkg::BIT_ERASE] = illegal_erase_evt;
    wr_status = '0;
    if (write_to(wr_pend_r, wr_addr_r, fds_pkg::ADDR_STATUS))
      wr_status = hwdata[fds_pkg::FAULT_W-1:0];
    // Set beats clear so a fault in the clearing cycle is kept
    status_nxt = (status_r & ~wr_status) | set_vec;
    wcan_nxt = illegal_write_evt;
    ecan_nxt = illegal_erase_evt;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_r <= fds_pkg::FAULT_RST;
      wcan_r <= 1'b0;
      ecan_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      wcan_r <= wcan_nxt;
      ecan_r <= ecan_nxt;
    end
  end

  // ==========================================================
  // Interrupt enable
  always_comb
  begin
    mask_nxt = mask_r;
    if (write_to(wr_pend_r, wr_addr_r, fds_pkg::ADDR_MASK))
      mask_nxt = hwdata[fds_pkg::FAULT_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mask_r <= fds_pkg::MASK_RST;
    else
      mask_r <= mask_nxt;
  end

  // ==========================================================
  // Target device select
  // Only the low bits are kept; the upper bits have no meaning
  always_comb
  begin
    sel_raw_nxt = sel_raw_r;
    if (write_to(wr_pend_r, wr_addr_r, fds_pkg::ADDR_SELECT))
      sel_raw_nxt = hwdata[fds_pkg::SEL_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sel_raw_r <= fds_pkg::SEL_RAW_RST;
      sel_r <= fds_pkg::SEL_FIRST;
    end
    else
    begin
      sel_raw_r <= sel_raw_nxt;
      sel_r <= sel_nxt;
    end
  end

  // ==========================================================
  // Interrupt
  // Built from next values so it moves on the same edge as the flags
  always_comb
  begin
    irq_nxt = 1'b0;
    if (status_nxt[fds_pkg::BIT_WRITE] && mask_nxt[fds_pkg::BIT_WRITE])
      irq_nxt = 1'b1;
    if (status_nxt[fds_pkg::BIT_ERASE] && mask_nxt[fds_pkg::BIT_ERASE])
      irq_nxt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_r <= 1'b0;
    else
      irq_r <= irq_nxt;
  end

  // ==========================================================
  // Outputs
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign device_select = sel_r;
  assign irq = irq_r;
  assign write_cancel = wcan_r;
  assign erase_cancel = ecan_r;

endmodule : fds_regs

/* test/fds_flash.sv */
// Flash-side model reporting protected-sector hits
`timescale 1ns/1ns
module fds_flash
(
  input wire logic clk,
  input wire logic wr_hit,
  input wire logic er_hit,
  output logic illegal_write_evt,
  output logic illegal_erase_evt
);
  always_ff @(posedge clk)
  begin
    illegal_write_evt <= wr_hit;
    illegal_erase_evt <= er_hit;
  end
endmodule : fds_flash

/* test/fds_regs_sva.sv */
// Checker for fault, interrupt and select timing
`timescale 1ns/1ns
module fds_chk
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic illegal_write_evt,
  input wire logic illegal_erase_evt,
  input wire logic write_cancel,
  input wire logic erase_cancel,
  input wire logic [fds_pkg::SEL_W-1:0] device_select,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_WCAN: assert property (illegal_write_evt |=> write_cancel)
    else $error("write not cancelled");
  AST_ECAN: assert property (illegal_erase_evt |=> erase_cancel)
    else $error("erase not cancelled");
  AST_WONE: assert property (
    write_cancel |-> $past(illegal_write_evt))
    else $error("stray write cancel");
  AST_EONE: assert property (
    erase_cancel |-> $past(illegal_erase_evt))
    else $error("stray erase cancel");
  AST_HOT: assert property ($onehot(device_select))
    else $error("select not one-hot");
  AST_SEL: assert property ($changed(device_select) |-> $past(hsel, 2))
    else $error("select moved unasked");
  AST_FALL: assert property ($fell(irq) |-> $past(hsel, 2))
    else $error("irq fell unasked");
  AST_RISE: assert property ($rose(irq) |-> $past(hsel, 2) ||
    $past(illegal_write_evt) || $past(illegal_erase_evt))
    else $error("irq rose unasked");
endmodule : fds_chk
bind fds_regs fds_chk chk_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
  .illegal_write_evt(illegal_write_evt), .irq(irq),
  .illegal_erase_evt(illegal_erase_evt), .write_cancel(write_cancel),
  .erase_cancel(erase_cancel), .device_select(device_select));

/* test/test_fds_regs.sv */
// Testbench for the fault/select register bank
`timescale 1ns/1ns
module test_fds_regs;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hready, we, ee, irq;
  logic wr_hit = 1'b0;
  logic er_hit = 1'b0;
  logic [2:0] sel;
  int mismatches = 0;
  int check_count = 0;
  int wc_n = 0;
  int ec_n = 0;
  logic resp, wc, ec, r;
  initial
  begin
    forever #5 clk = ~clk;
  end
  fds_regs dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(fds_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(resp), .illegal_write_evt(we), .illegal_erase_evt(ee), .irq(irq),
    .write_cancel(wc), .erase_cancel(ec), .device_select(sel));
  fds_flash flash_u (.clk(clk), .wr_hit(wr_hit), .er_hit(er_hit),
    .illegal_write_evt(we), .illegal_erase_evt(ee));
  // Cancel pulses counted so each scenario can judge how many came
  always @(posedge clk)
  begin
    wc_n <= wc_n + int'(wc);
    ec_n <= ec_n + int'(ec);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      mismatches++;
      wrap_up();
    end
  endtask : rdy
  task automatic xf(input logic w, input logic [7:0] a, input int d);
    hsel <= 1'b1;
    htrans <= fds_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    r = resp;
  endtask : xf
  task automatic t_sel;
    logic [2:0] wv [8] = '{3'h4, 3'h2, 3'h0, 3'h2, 3'h1, 3'h6, 3'h4, 3'h7};
    logic [2:0] ex;
    foreach (wv[i])
    begin
      ex = (wv[i] == 3'h4 || wv[i] == 3'h2) ? wv[i] : 3'h1;
      xf(1'b1, fds_pkg::ADDR_SELECT, int'(wv[i]));
      chk(32'(r), 32'h0);
      @(posedge clk);
      chk(32'(sel), 32'(ex));
    end
    xf(1'b0, fds_pkg::ADDR_SELECT, 0);
    chk(q, 32'h0);
    xf(1'b0, 8'h0c, 0);
    chk(q, 32'h0);
  endtask : t_sel
  task automatic t_flt(input int b);
    int w0;
    int e0;
    w0 = wc_n;
    e0 = ec_n;
    wr_hit <= (b == 1);
    er_hit <= (b == 0);
    @(posedge clk);
    wr_hit <= 1'b0;
    er_hit <= 1'b0;
    xf(1'b1, fds_pkg::ADDR_MASK, 1 << (1 - b));
    xf(1'b0, fds_pkg::ADDR_STATUS, 0);
    chk(q, 32'h1 << b);
    chk(32'(irq), 32'h0);
    xf(1'b1, fds_pkg::ADDR_MASK, 1 << b);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    // A new fault in the clearing write's data phase must survive
    fork
      xf(1'b1, fds_pkg::ADDR_STATUS, 1 << b);
      begin
        wr_hit <= (b == 1);
        er_hit <= (b == 0);
        @(posedge clk);
        wr_hit <= 1'b0;
        er_hit <= 1'b0;
      end
    join
    @(posedge clk);
    chk(32'(irq), 32'h1);
    xf(1'b0, fds_pkg::ADDR_STATUS, 0);
    chk(q, 32'h1 << b);
    xf(1'b1, fds_pkg::ADDR_STATUS, 1 << b);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    chk(wc_n - w0, (b == 1) ? 2 : 0);
    chk(ec_n - e0, (b == 0) ? 2 : 0);
  endtask : t_flt
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    xf(1'b0, fds_pkg::ADDR_MASK, 0);
    chk(q, 32'h0);
    chk(32'(sel), 32'h1);
    t_sel();
    t_flt(1);
    t_flt(0);
    wrap_up();
  end
endmodule : test_fds_regs
